/* verilog/hss_diag_pkg.sv */
package hss_diag_pkg;
    // ****************************************
    // channel count and timing
    // ****************************************
    localparam int NUM_CH = 2;
    localparam int CLK_FREQ_HZ = 25000000;
    // led check period in microseconds, figure is a plain default
    localparam int LED_CHECK_PERIOD_US = 1000;
    localparam int LED_CHECK_CYCLES = LED_CHECK_PERIOD_US * (CLK_FREQ_HZ / 1000000);
    localparam int LED_CNT_W = 16;
    // ****************************************
    // duty code for fully on
    // ****************************************
    localparam logic [6:0] DUTY_FULL_ON = 7'h7f;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic CFG_BIT_RESET = 1'h0;
    // ****************************************
    // feedback routing codes
    // ****************************************
    typedef enum logic [1:0] {
        FB_OFF = 2'b00,
        FB_CURRENT = 2'b01,
        FB_TEMPERATURE = 2'b10
    } feedback_route_t;
endpackage

/* verilog/led_check_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module led_check_timer
    import hss_diag_pkg::*;
#(
    parameter int PERIOD_CYCLES = LED_CHECK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_clr,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [LED_CNT_W-1:0] cnt;
        logic tick;
    } timer_state_t;
    timer_state_t state_reg;
    timer_state_t state_next;
    always_comb
    begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (sync_clr || !run)
        begin
            state_next.cnt = '0;
        end
        else if (state_reg.cnt == LED_CNT_W'(PERIOD_CYCLES - 1))
        begin
            state_next.cnt = '0;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.cnt = state_reg.cnt + LED_CNT_W'(1);
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign tick = state_reg.tick;
endmodule
`default_nettype wire

/* verilog/sync_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_flag
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_clr,
    input wire logic set_cond,
    input wire logic clr_req,
    input wire logic clr_allow,
    output logic flag
);
    // latched flag: set wins over a read clear in the same cycle; sync_clr wins over set
    typedef struct packed {
        logic flag;
    } flag_state_t;
    flag_state_t state_reg;
    flag_state_t state_next;
    always_comb
    begin
        state_next = state_reg;
        if (sync_clr)
        begin
            state_next.flag = 1'b0;
        end
        else if (set_cond)
        begin
            state_next.flag = 1'b1;
        end
        else if (clr_req && clr_allow)
        begin
            state_next.flag = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign flag = state_reg.flag;
endmodule
`default_nettype wire

/* verilog/high_side_switch_diagnostics.sv */
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_diagnostics
    import hss_diag_pkg::*;
#(
    parameter int LED_PERIOD_CYCLES = LED_CHECK_CYCLES
)
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic LOGIC_SUPPLY_OK,
    input wire logic LOGIC_SUPPLY_ABOVE_FAIL,
    input wire logic BATTERY_SUPPLY_OK,
    input wire logic BATTERY_ABOVE_CLAMP,
    input wire logic SUPPLIES_ABOVE_POR,
    input wire logic GROUND_OK,
    input wire logic FAIL_SAFE_MODE,
    input wire logic STATUS_READ,
    input wire logic CFG_WRITE,
    input wire logic CFG_FAIL_ENABLE,
    input wire logic [1:0] CFG_SHORT_DETECT_DISABLE,
    input wire logic [1:0] CFG_OFF_OPEN_LOAD_DISABLE,
    input wire logic [1:0] CFG_ON_OPEN_LOAD_DISABLE,
    input wire logic [1:0] CFG_LED_OPEN_LOAD_SELECT,
    input wire logic CFG_TEMP_ENABLE,
    input wire logic CFG_FEEDBACK_ENABLE,
    input wire logic CFG_FEEDBACK_CHANNEL_SELECT,
    input wire logic CFG_FEEDBACK_RATIO_SELECT,
    input wire logic [6:0] CFG_DUTY_CH0,
    input wire logic [6:0] CFG_DUTY_CH1,
    input wire logic [1:0] CFG_ON_COMMAND,
    input wire logic [1:0] DIRECT_IN,
    input wire logic [1:0] GATE_LOW,
    input wire logic [1:0] OUT_ABOVE_SHORT_THRESH,
    input wire logic [1:0] OUT_ABOVE_OPEN_THRESH,
    input wire logic [1:0] PULLUP_ACTIVE,
    input wire logic [1:0] CURRENT_BELOW_BULB_THRESH,
    input wire logic [1:0] CURRENT_BELOW_LED_THRESH,
    input wire logic [1:0] OVERLOAD_TURN_OFF,
    input wire logic TEMP_ABOVE_WARNING,
    output logic [1:0] SWITCH_OUTPUTS,
    output logic [1:0] LED_THRESHOLD_SELECT,
    output logic FAULT_STATUS_PIN,
    output logic [1:0] SHORT_TO_SUPPLY_FLAG,
    output logic [1:0] OFF_OPEN_LOAD_FLAG,
    output logic [1:0] ON_OPEN_LOAD_FLAG_PAIR,
    output logic TEMPERATURE_PREWARNING_FLAG,
    output logic UNDERVOLTAGE_FLAG,
    output logic [1:0] FEEDBACK_ROUTE,
    output logic FEEDBACK_CHANNEL,
    output logic FEEDBACK_RATIO,
    output logic FEEDBACK_ACTIVE
);
    // ****************************************
    // configuration state
    // ****************************************
    typedef struct packed {
        logic fail_en;
        logic [1:0] short_dis;
        logic [1:0] off_ol_dis;
        logic [1:0] on_ol_dis;
        logic [1:0] led_sel;
        logic temp_en;
        logic fb_en;
        logic fb_ch;
        logic fb_ratio;
        logic [6:0] duty0;
        logic [6:0] duty1;
        logic [1:0] on_cmd;
    } cfg_t;
    typedef struct packed {
        cfg_t cfg;
        logic uv;
        logic temperature_prewarning_flag;
        logic [1:0] sw;
        logic fault_n;
        logic [1:0] route;
        logic fb_ch;
        logic fb_ratio;
        logic fb_active;
    } top_state_t;
    top_state_t state_reg;
    top_state_t state_next;
    // ****************************************
    // resets from supply loss
    // ****************************************
    logic logic_supply_lost;
    logic por_reset;
    logic reg_clear;
    logic [1:0] ch_on;
    logic [1:0] short_now;
    logic [1:0] off_ol_now;
    logic [1:0] on_ol_now;
    logic [1:0] led_tick;
    logic [1:0] led_run;
    logic [1:0] short_flag;
    logic [1:0] off_ol_flag;
    logic [1:0] on_ol_flag;
    logic any_off_fault;
    assign logic_supply_lost = !LOGIC_SUPPLY_OK
        || (!LOGIC_SUPPLY_ABOVE_FAIL && state_reg.cfg.fail_en);
    assign por_reset = !SUPPLIES_ABOVE_POR;
    // latched faults survive a logic-supply loss; only power-on or an allowed status read clears them
    assign reg_clear = logic_supply_lost || por_reset;
    // ****************************************
    // channel detection
    // ****************************************
    function automatic logic duty_full(input logic [6:0] duty);
        duty_full = (duty == DUTY_FULL_ON);
    endfunction
    assign ch_on = state_reg.sw;
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            // off flags need the gate fully pulled low before latching
            short_now[i] = !ch_on[i] && GATE_LOW[i] && OUT_ABOVE_SHORT_THRESH[i]
                && !state_reg.cfg.short_dis[i];
            off_ol_now[i] = !ch_on[i] && GATE_LOW[i] && PULLUP_ACTIVE[i]
                && OUT_ABOVE_OPEN_THRESH[i] && !state_reg.cfg.off_ol_dis[i];
            if (state_reg.cfg.led_sel[i])
            begin
                // tick may lag a turn-off by one edge, so the channel must still be on
                on_ol_now[i] = ch_on[i] && led_tick[i] && CURRENT_BELOW_LED_THRESH[i];
            end
            else
            begin
                on_ol_now[i] = ch_on[i] && CURRENT_BELOW_BULB_THRESH[i];
            end
            on_ol_now[i] = on_ol_now[i] && !state_reg.cfg.on_ol_dis[i];
        end
    end
    // led check runs only while fully on; the controller holds it on a full period
    assign led_run[0] = ch_on[0] && state_reg.cfg.led_sel[0] && duty_full(state_reg.cfg.duty0);
    assign led_run[1] = ch_on[1] && state_reg.cfg.led_sel[1] && duty_full(state_reg.cfg.duty1);
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        led_check_timer #(
            .PERIOD_CYCLES(LED_PERIOD_CYCLES)
        ) u_timer (
            .clk(CORE_CLK),
            .rst_n(NRST),
            .sync_clr(reg_clear),
            .run(led_run[g]),
            .tick(led_tick[g])
        );
        sync_flag u_short (
            .clk(CORE_CLK),
            .rst_n(NRST),
            .sync_clr(por_reset),
            .set_cond(short_now[g]),
            .clr_req(STATUS_READ),
            .clr_allow(!OUT_ABOVE_SHORT_THRESH[g]),
            .flag(short_flag[g])
        );
        sync_flag u_off_ol (
            .clk(CORE_CLK),
            .rst_n(NRST),
            .sync_clr(por_reset),
            .set_cond(off_ol_now[g] || short_now[g]),
            .clr_req(STATUS_READ),
            .clr_allow(state_reg.fault_n),
            .flag(off_ol_flag[g])
        );
        // on-open clearing waits until the live comparator of the selected mode is clear or the channel is off
        sync_flag u_on_ol (
            .clk(CORE_CLK),
            .rst_n(NRST),
            .sync_clr(por_reset),
            .set_cond(on_ol_now[g]),
            .clr_req(STATUS_READ),
            .clr_allow(!(ch_on[g] && (state_reg.cfg.led_sel[g]
                ? CURRENT_BELOW_LED_THRESH[g] : CURRENT_BELOW_BULB_THRESH[g]))),
            .flag(on_ol_flag[g])
        );
    end
    assign any_off_fault = |short_now || |(off_ol_now & ~state_reg.cfg.off_ol_dis);
    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        if (reg_clear)
        begin
            state_next.cfg = '0;
        end
        // writes land whatever the battery does; logic supply loss or power-on reset wipes config
        else if (CFG_WRITE)
        begin
            state_next.cfg.fail_en = CFG_FAIL_ENABLE;
            state_next.cfg.short_dis = CFG_SHORT_DETECT_DISABLE;
            state_next.cfg.off_ol_dis = CFG_OFF_OPEN_LOAD_DISABLE;
            state_next.cfg.on_ol_dis = CFG_ON_OPEN_LOAD_DISABLE;
            state_next.cfg.led_sel = CFG_LED_OPEN_LOAD_SELECT;
            state_next.cfg.temp_en = CFG_TEMP_ENABLE;
            state_next.cfg.fb_en = CFG_FEEDBACK_ENABLE;
            state_next.cfg.fb_ch = CFG_FEEDBACK_CHANNEL_SELECT;
            state_next.cfg.fb_ratio = CFG_FEEDBACK_RATIO_SELECT;
            state_next.cfg.duty0 = CFG_DUTY_CH0;
            state_next.cfg.duty1 = CFG_DUTY_CH1;
            state_next.cfg.on_cmd = CFG_ON_COMMAND;
        end
        // undervoltage: set wins over the read clear
        if (por_reset)
        begin
            state_next.uv = 1'b0;
        end
        else if (!BATTERY_SUPPLY_OK)
        begin
            state_next.uv = 1'b1;
        end
        else if (STATUS_READ)
        begin
            state_next.uv = 1'b0;
        end
        if (por_reset)
        begin
            state_next.temperature_prewarning_flag = 1'b0;
        end
        else if (TEMP_ABOVE_WARNING && !FAIL_SAFE_MODE)
        begin
            state_next.temperature_prewarning_flag = 1'b1;
        end
        else if (STATUS_READ)
        begin
            state_next.temperature_prewarning_flag = 1'b0;
        end
        // output drive: ground loss beats everything, clamp beats overload turn-off
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!GROUND_OK)
            begin
                state_next.sw[i] = 1'b0;
            end
            else if (BATTERY_ABOVE_CLAMP && |OVERLOAD_TURN_OFF)
            begin
                state_next.sw[i] = 1'b1;
            end
            else if (OVERLOAD_TURN_OFF[i] || !BATTERY_SUPPLY_OK)
            begin
                state_next.sw[i] = 1'b0;
            end
            else
            begin
                // with the logic supply down, config is zero and direct inputs
                state_next.sw[i] = DIRECT_IN[i] || (!logic_supply_lost && state_reg.cfg.on_cmd[i]);
            end
        end
        state_next.fault_n = !any_off_fault;
        // feedback routing
        state_next.fb_ch = state_reg.cfg.fb_ch;
        state_next.fb_ratio = state_reg.cfg.fb_ratio;
        if (state_reg.cfg.temp_en)
        begin
            state_next.route = FB_TEMPERATURE;
        end
        else if (state_reg.cfg.fb_en)
        begin
            state_next.route = FB_CURRENT;
        end
        else
        begin
            state_next.route = FB_OFF;
        end
        state_next.fb_active = state_reg.cfg.fb_en && !state_reg.cfg.temp_en
            && state_reg.sw[state_reg.cfg.fb_ch] && !FAIL_SAFE_MODE;
    end
    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_reg <= '0;
            state_reg.fault_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign SWITCH_OUTPUTS = state_reg.sw;
    assign LED_THRESHOLD_SELECT = state_reg.cfg.led_sel;
    assign FAULT_STATUS_PIN = state_reg.fault_n;
    assign SHORT_TO_SUPPLY_FLAG = short_flag;
    assign OFF_OPEN_LOAD_FLAG = off_ol_flag;
    assign ON_OPEN_LOAD_FLAG_PAIR = on_ol_flag;
    assign TEMPERATURE_PREWARNING_FLAG = state_reg.temperature_prewarning_flag;
    assign UNDERVOLTAGE_FLAG = state_reg.uv;
    assign FEEDBACK_ROUTE = state_reg.route;
    assign FEEDBACK_CHANNEL = state_reg.fb_ch;
    assign FEEDBACK_RATIO = state_reg.fb_ratio;
    assign FEEDBACK_ACTIVE = state_reg.fb_active;
endmodule
`default_nettype wire

/* testbench/hss_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hss_host_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_go,
    input wire logic wr_go,
    output logic status_read,
    output logic cfg_write
);
    // strobes leave on an edge so the design never sees a half-cycle pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_read <= 1'h0;
            cfg_write <= 1'h0;
        end
        else
        begin
            status_read <= rd_go;
            cfg_write <= wr_go;
        end
    end
endmodule
`default_nettype wire

/* testbench/hss_diag_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module hss_diag_assertions
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic LOGIC_SUPPLY_OK,
    input wire logic BATTERY_ABOVE_CLAMP,
    input wire logic SUPPLIES_ABOVE_POR,
    input wire logic GROUND_OK,
    input wire logic FAIL_SAFE_MODE,
    input wire logic STATUS_READ,
    input wire logic [1:0] OVERLOAD_TURN_OFF,
    input wire logic TEMP_ABOVE_WARNING,
    input wire logic [1:0] SWITCH_OUTPUTS,
    input wire logic [1:0] LED_THRESHOLD_SELECT,
    input wire logic FAULT_STATUS_PIN,
    input wire logic [1:0] SHORT_TO_SUPPLY_FLAG,
    input wire logic [1:0] OFF_OPEN_LOAD_FLAG,
    input wire logic [1:0] ON_OPEN_LOAD_FLAG_PAIR,
    input wire logic TEMPERATURE_PREWARNING_FLAG,
    input wire logic FEEDBACK_ACTIVE
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);
    property p_short_fault;
        $rose(SHORT_TO_SUPPLY_FLAG[0]) |-> !FAULT_STATUS_PIN;
    endproperty
    a_short_fault: assert property (p_short_fault) else $error("short without fault pin");
    property p_on_open;
        $rose(ON_OPEN_LOAD_FLAG_PAIR[0]) |-> $past(SWITCH_OUTPUTS[0]);
    endproperty
    a_on_open: assert property (p_on_open) else $error("on open flag while off");
    property p_temp_hold;
        TEMPERATURE_PREWARNING_FLAG && !STATUS_READ && SUPPLIES_ABOVE_POR |=> TEMPERATURE_PREWARNING_FLAG;
    endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("warning lost without read");
    property p_temp_set;
        TEMP_ABOVE_WARNING && !FAIL_SAFE_MODE && SUPPLIES_ABOVE_POR |=> TEMPERATURE_PREWARNING_FLAG;
    endproperty
    a_temp_set: assert property (p_temp_set) else $error("warning not set");
    property p_fb_failsafe;
        FAIL_SAFE_MODE |=> !FEEDBACK_ACTIVE;
    endproperty
    a_fb_failsafe: assert property (p_fb_failsafe) else $error("feedback in fail-safe");
    property p_clamp;
        OVERLOAD_TURN_OFF[0] && BATTERY_ABOVE_CLAMP && GROUND_OK |=> SWITCH_OUTPUTS == 2'h3;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp did not turn both on");
    property p_ground;
        !GROUND_OK |=> SWITCH_OUTPUTS == 2'h0;
    endproperty
    a_ground: assert property (p_ground) else $error("output on without ground");
    property p_por;
        !SUPPLIES_ABOVE_POR |=> SHORT_TO_SUPPLY_FLAG == 2'h0 && OFF_OPEN_LOAD_FLAG == 2'h0;
    endproperty
    a_por: assert property (p_por) else $error("flags kept below power-on level");
    property p_logic_loss;
        !LOGIC_SUPPLY_OK |=> LED_THRESHOLD_SELECT == 2'h0;
    endproperty
    a_logic_loss: assert property (p_logic_loss) else $error("config kept on logic loss");
endmodule
bind high_side_switch_diagnostics hss_diag_assertions hss_diag_assertions_i (.*);
`default_nettype wire

/* testbench/high_side_switch_diagnostics_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_diagnostics_tb
    import hss_diag_pkg::*;
;
    localparam int led_period = 8;
    logic CORE_CLK = 1'h0, NRST = 1'h0, LOGIC_SUPPLY_OK = 1'h1, LOGIC_SUPPLY_ABOVE_FAIL = 1'h1;
    logic BATTERY_SUPPLY_OK = 1'h1, BATTERY_ABOVE_CLAMP = 1'h0, SUPPLIES_ABOVE_POR = 1'h1;
    logic GROUND_OK = 1'h1, FAIL_SAFE_MODE = 1'h0, CFG_FAIL_ENABLE = 1'h0, CFG_TEMP_ENABLE = 1'h0;
    logic CFG_FEEDBACK_ENABLE = 1'h0, CFG_FEEDBACK_CHANNEL_SELECT = 1'h0;
    logic CFG_FEEDBACK_RATIO_SELECT = 1'h0, TEMP_ABOVE_WARNING = 1'h0;
    logic rd_go = 1'h0, wr_go = 1'h0, STATUS_READ, CFG_WRITE;
    logic [6:0] CFG_DUTY_CH0 = 7'h0, CFG_DUTY_CH1 = 7'h0;
    logic [1:0] CFG_SHORT_DETECT_DISABLE = 2'h0, CFG_OFF_OPEN_LOAD_DISABLE = 2'h0;
    logic [1:0] CFG_ON_OPEN_LOAD_DISABLE = 2'h0, CFG_LED_OPEN_LOAD_SELECT = 2'h0;
    logic [1:0] CFG_ON_COMMAND = 2'h0, DIRECT_IN = 2'h0, GATE_LOW = 2'h0, PULLUP_ACTIVE = 2'h0;
    logic [1:0] OUT_ABOVE_SHORT_THRESH = 2'h0, OUT_ABOVE_OPEN_THRESH = 2'h0;
    logic [1:0] CURRENT_BELOW_BULB_THRESH = 2'h0, CURRENT_BELOW_LED_THRESH = 2'h0;
    logic [1:0] OVERLOAD_TURN_OFF = 2'h0, SWITCH_OUTPUTS, LED_THRESHOLD_SELECT, FEEDBACK_ROUTE;
    logic [1:0] SHORT_TO_SUPPLY_FLAG, OFF_OPEN_LOAD_FLAG, ON_OPEN_LOAD_FLAG_PAIR;
    logic FAULT_STATUS_PIN, TEMPERATURE_PREWARNING_FLAG, UNDERVOLTAGE_FLAG;
    logic FEEDBACK_CHANNEL, FEEDBACK_RATIO, FEEDBACK_ACTIVE;
    int fail_count = 0, checked = 0;
    high_side_switch_diagnostics #(.LED_PERIOD_CYCLES(led_period)) high_side_switch_diagnostics_i (.*);
    hss_host_model hss_host_model_i (.clk(CORE_CLK), .rst_n(NRST), .rd_go(rd_go), .wr_go(wr_go),
        .status_read(STATUS_READ), .cfg_write(CFG_WRITE));
    always #20 CORE_CLK = ~CORE_CLK;
    task cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    // host strobe lags one edge, so three more edges cover load and effect
    task rd;
        rd_go = 1'h1;
        cyc(1);
        rd_go = 1'h0;
        cyc(3);
    endtask
    task wr;
        wr_go = 1'h1;
        cyc(1);
        wr_go = 1'h0;
        cyc(3);
    endtask
    task chk(input logic [1:0] s, input logic [1:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        end_of_test;
    end
    initial
    begin
        cyc(20);
        NRST = 1'h1;
        cyc(2);
        chk(FAULT_STATUS_PIN, 2'h1);
        GATE_LOW = 2'h3;
        OUT_ABOVE_SHORT_THRESH = 2'h1;
        cyc(3);
        chk(SHORT_TO_SUPPLY_FLAG, 2'h1);
        chk(OFF_OPEN_LOAD_FLAG, 2'h1);
        chk(FAULT_STATUS_PIN, 2'h0);
        rd;
        chk(SHORT_TO_SUPPLY_FLAG, 2'h1);
        chk(OFF_OPEN_LOAD_FLAG, 2'h1);
        OUT_ABOVE_SHORT_THRESH = 2'h0;
        cyc(3);
        chk(FAULT_STATUS_PIN, 2'h1);
        rd;
        chk(SHORT_TO_SUPPLY_FLAG, 2'h0);
        chk(OFF_OPEN_LOAD_FLAG, 2'h0);
        PULLUP_ACTIVE = 2'h2;
        OUT_ABOVE_OPEN_THRESH = 2'h2;
        cyc(3);
        chk(OFF_OPEN_LOAD_FLAG, 2'h2);
        CFG_SHORT_DETECT_DISABLE = 2'h1;
        CFG_OFF_OPEN_LOAD_DISABLE = 2'h2;
        OUT_ABOVE_OPEN_THRESH = 2'h0;
        wr;
        rd;
        chk(OFF_OPEN_LOAD_FLAG, 2'h0);
        OUT_ABOVE_SHORT_THRESH = 2'h1;
        OUT_ABOVE_OPEN_THRESH = 2'h2;
        cyc(3);
        chk(SHORT_TO_SUPPLY_FLAG, 2'h0);
        chk(OFF_OPEN_LOAD_FLAG, 2'h0);
        chk(FAULT_STATUS_PIN, 2'h1);
        OUT_ABOVE_SHORT_THRESH = 2'h0;
        OUT_ABOVE_OPEN_THRESH = 2'h0;
        GATE_LOW = 2'h0;
        CFG_ON_COMMAND = 2'h1;
        CFG_ON_OPEN_LOAD_DISABLE = 2'h1;
        CURRENT_BELOW_BULB_THRESH = 2'h1;
        wr;
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h0);
        CFG_ON_OPEN_LOAD_DISABLE = 2'h0;
        wr;
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h1);
        chk(SWITCH_OUTPUTS, 2'h1);
        chk(FAULT_STATUS_PIN, 2'h1);
        rd;
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h1);
        CURRENT_BELOW_BULB_THRESH = 2'h0;
        cyc(3);
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h1);
        rd;
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h0);
        // led mode must ignore the bulb comparator
        CFG_LED_OPEN_LOAD_SELECT = 2'h1;
        CFG_DUTY_CH0 = DUTY_FULL_ON;
        wr;
        // bulb comparator rises only once led mode is loaded, else bulb mode latches it
        CURRENT_BELOW_BULB_THRESH = 2'h1;
        chk(LED_THRESHOLD_SELECT, 2'h1);
        cyc(led_period + 4);
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h0);
        CURRENT_BELOW_LED_THRESH = 2'h1;
        cyc(led_period + 4);
        chk(ON_OPEN_LOAD_FLAG_PAIR, 2'h1);
        CURRENT_BELOW_LED_THRESH = 2'h0;
        CURRENT_BELOW_BULB_THRESH = 2'h0;
        CFG_FEEDBACK_ENABLE = 1'h1;
        CFG_FEEDBACK_RATIO_SELECT = 1'h1;
        wr;
        chk(FEEDBACK_ROUTE, FB_CURRENT);
        chk(FEEDBACK_RATIO, 2'h1);
        chk(FEEDBACK_ACTIVE, 2'h1);
        FAIL_SAFE_MODE = 1'h1;
        TEMP_ABOVE_WARNING = 1'h1;
        cyc(3);
        chk(FEEDBACK_ACTIVE, 2'h0);
        chk(TEMPERATURE_PREWARNING_FLAG, 2'h0);
        FAIL_SAFE_MODE = 1'h0;
        TEMP_ABOVE_WARNING = 1'h0;
        CFG_FEEDBACK_CHANNEL_SELECT = 1'h1;
        wr;
        chk(FEEDBACK_CHANNEL, 2'h1);
        chk(FEEDBACK_ACTIVE, 2'h0);
        CFG_TEMP_ENABLE = 1'h1;
        wr;
        chk(FEEDBACK_ROUTE, FB_TEMPERATURE);
        TEMP_ABOVE_WARNING = 1'h1;
        cyc(3);
        TEMP_ABOVE_WARNING = 1'h0;
        cyc(3);
        chk(TEMPERATURE_PREWARNING_FLAG, 2'h1);
        rd;
        chk(TEMPERATURE_PREWARNING_FLAG, 2'h0);
        CFG_ON_COMMAND = 2'h0;
        wr;
        OVERLOAD_TURN_OFF = 2'h1;
        BATTERY_ABOVE_CLAMP = 1'h1;
        cyc(3);
        chk(SWITCH_OUTPUTS, 2'h3);
        OVERLOAD_TURN_OFF = 2'h0;
        BATTERY_ABOVE_CLAMP = 1'h0;
        CFG_ON_COMMAND = 2'h3;
        wr;
        GROUND_OK = 1'h0;
        cyc(3);
        chk(SWITCH_OUTPUTS, 2'h0);
        GROUND_OK = 1'h1;
        BATTERY_SUPPLY_OK = 1'h0;
        cyc(3);
        chk(UNDERVOLTAGE_FLAG, 2'h1);
        chk(LED_THRESHOLD_SELECT, 2'h1);
        BATTERY_SUPPLY_OK = 1'h1;
        CFG_FAIL_ENABLE = 1'h1;
        wr;
        rd;
        chk(UNDERVOLTAGE_FLAG, 2'h0);
        LOGIC_SUPPLY_ABOVE_FAIL = 1'h0;
        cyc(3);
        chk(LED_THRESHOLD_SELECT, 2'h0);
        LOGIC_SUPPLY_ABOVE_FAIL = 1'h1;
        wr;
        LOGIC_SUPPLY_OK = 1'h0;
        DIRECT_IN = 2'h2;
        GATE_LOW = 2'h1;
        OUT_ABOVE_SHORT_THRESH = 2'h1;
        cyc(3);
        chk(LED_THRESHOLD_SELECT, 2'h0);
        chk(SWITCH_OUTPUTS, 2'h2);
        chk(SHORT_TO_SUPPLY_FLAG, 2'h1);
        OUT_ABOVE_SHORT_THRESH = 2'h0;
        SUPPLIES_ABOVE_POR = 1'h0;
        cyc(3);
        chk(SHORT_TO_SUPPLY_FLAG, 2'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
